// ===== design/wake_pkg.sv
// Purpose: shared constants and types of the wake event indication block
// Assumes: 100 MHz pclk, 32-bit APB with 12-bit byte addresses
// Notes: bit positions follow the power and wake control word
package wake_pkg;

    localparam int ADDR_W = 12;

    // register byte addresses
    localparam logic [11:0] PWC_OFF = 12'h084;
    localparam logic [11:0] HWCFG_OFF = 12'h070;
    localparam logic [11:0] BYTE_TEST_OFF = 12'h064;

    // power_wake_control field positions
    localparam int PSTATE_HI = 13;
    localparam int PSTATE_LO = 12;
    localparam int NET_EN_BIT = 9;
    localparam int ENERGY_DETECT_ENABLE_BIT = 8;
    localparam int TYPE_BIT = 6;
    localparam int CAUSE_HI = 5;
    localparam int CAUSE_LO = 4;
    localparam int PULSE_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int PIN_EN_BIT = 1;
    localparam int READY_BIT = 0;

    // wake cause bit indices within the two-bit field
    localparam int CAUSE_ED_IDX = 0;
    localparam int CAUSE_NET_IDX = 1;

    // wake cause codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_ENERGY = 2'h1;
    localparam logic [1:0] CAUSE_NET = 2'h2;
    localparam logic [1:0] CAUSE_MULTI = 2'h3;

    // power state select encodings
    localparam logic [1:0] PS_NORMAL = 2'h0;
    localparam logic [1:0] PS_NET_DETECT = 2'h1;
    localparam logic [1:0] PS_ENERGY = 2'h2;
    localparam logic [1:0] PS_RESERVED = 2'h3;

    // reset values
    localparam logic [31:0] HWCFG_RESET = 32'h0000_0000;
    // arbitrary fixed pattern read back from the byte order test register
    localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

    // timing
    localparam int CLK_KHZ = 100000;
    localparam int PULSE_MS = 50;
    localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;
    localparam int STABLE_US = 20;
    localparam int STABLE_CYCLES = (STABLE_US * CLK_KHZ + 999) / 1000;

    typedef struct packed {
        logic [1:0] pstate;
        logic net_en;
        logic energy_detect_enable;
        logic drive_pp;
        logic pulse;
        logic pol;
        logic pin_en;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

endpackage : wake_pkg

// ===== design/cycle_timer.sv
// Purpose: down counter that stays busy for a set number of cycles
// Assumes: start is a one-cycle pulse; a new start restarts the count
// Notes: done pulses in the last busy cycle
`timescale 1ns/10ps
module cycle_timer
#(
    parameter int WIDTH = 32,
    parameter int LOAD = 1
)
(
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic start, // begin a new count
    output logic busy, // count running
    output logic done // last cycle of the count
);

    localparam logic [WIDTH-1:0] LOAD_V = WIDTH'(LOAD);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    logic [WIDTH-1:0] count_q;

    generate
        if (LOAD < 1 || (WIDTH < 32 && LOAD >= (1 << WIDTH)))
        begin : g_bad
            $error("cycle_timer: LOAD does not fit WIDTH");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (start)
            count_q <= LOAD_V;
        else if (count_q != '0)
            count_q <= count_q - ONE;
    end

    assign busy = (count_q != '0);
    assign done = (count_q == ONE) && !start;

endmodule : cycle_timer

// ===== design/wake_event_indication.sv
// Purpose: wake event gating, wake pin drive and device ready control
// Assumes: APB slave, zero wait states, event inputs synchronous to pclk
// Notes: event inputs are levels held by the detectors until serviced
//
// Overview of operation
// - network wake drives enabled pin per mode
// - network wake raises interrupt regardless pin enable
// - energy detect drives enabled pin per mode
// - energy detect raises interrupt regardless pin enable
// - drive type selects open-drain or push-pull
// - open-drain ignores polarity, always active low
// - cause field encodes none, energy, frame, multiple
// - cause bits write-one-clear only when ready
// - pulse mode holds pin active 50 ms
// - static mode holds pin active continuously
// - clearing cause or enable releases pin
// - push-pull polarity bit sets active level
// - pin enable gates pin, not interrupt
// - ready flag after stabilizing; register always readable
// - while not ready, only two registers readable
// - power state encodings normal, frame, energy
// - byte test write wakes reduced state
`timescale 1ns/10ps
module wake_event_indication
#(
    parameter int PULSE_CYCLES = wake_pkg::PULSE_CYCLES,
    parameter int STABLE_CYCLES = wake_pkg::STABLE_CYCLES
)
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic network_wake, // network wake event level
    input wire logic energy_detect, // energy detect event level
    output logic wake_event_pin_o, // wake pin output value
    output logic wake_event_pin_oe, // wake pin output enable
    output logic wake_interrupt, // internal wake interrupt
    output logic [1:0] power_state_select // current power state
);

    typedef enum logic [1:0] {
        ST_STABILIZE,
        ST_READY,
        ST_REDUCED
    } dev_state_t;

    // both timers share one counter width
    localparam int TIMER_W = 32;

    generate
        if (PULSE_CYCLES < 1 || STABLE_CYCLES < 1)
        begin : g_bad
            $error("wake_event_indication: timing counts must be >= 1");
        end
    endgenerate

    generate
        if (wake_pkg::PSTATE_HI - wake_pkg::PSTATE_LO != 1
            || wake_pkg::CAUSE_HI - wake_pkg::CAUSE_LO != 1)
        begin : g_bad_fields
            $error("wake_event_indication: two-bit fields expected");
        end
    endgenerate

    wake_pkg::ctrl_t ctrl_q;
    dev_state_t state_q;
    logic [1:0] cause_q;
    logic [31:0] hwcfg_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic start_q;
    logic active_q;
    logic pin_q;
    logic oe_q;
    logic irq_q;

    logic ready;
    logic setup;
    logic wr_access;
    logic hit_pwc;
    logic hit_hwcfg;
    logic hit_test;
    logic rd_ok;
    logic wr_ok;
    logic wr_pwc;
    logic wr_test;
    logic [1:0] new_pstate;
    logic [1:0] cause_set;
    logic [1:0] cause_clr;
    logic [1:0] source_live;
    logic wake_active;
    logic pulse_busy;
    logic stable_done;
    logic pin_assert;
    logic [31:0] pwc_word;
    logic [31:0] read_mux;
    logic [1:0] cause_d;
    logic pulse_start;
    logic pin_d;
    logic oe_d;
    logic wr_hwcfg;

    assign ready = (state_q == ST_READY);
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;

    assign hit_pwc = (paddr == wake_pkg::PWC_OFF);
    assign hit_hwcfg = (paddr == wake_pkg::HWCFG_OFF);
    assign hit_test = (paddr == wake_pkg::BYTE_TEST_OFF);

    // reads: two registers stay reachable in every state
    assign rd_ok = hit_pwc || hit_hwcfg || (hit_test && ready);
    // writes: only the byte test register before ready
    assign wr_ok = ready ? (hit_pwc || hit_hwcfg || hit_test)
                         : hit_test;

    assign wr_pwc = wr_access && hit_pwc && ready;
    assign wr_test = wr_access && hit_test;
    assign wr_hwcfg = wr_access && hit_hwcfg && ready;
    assign new_pstate = pwdata[wake_pkg::PSTATE_HI:wake_pkg::PSTATE_LO];

    // readback word of the power and wake control register
    always_comb
    begin
        pwc_word = '0;
        pwc_word[wake_pkg::PSTATE_HI:wake_pkg::PSTATE_LO] = ctrl_q.pstate;
        pwc_word[wake_pkg::NET_EN_BIT] = ctrl_q.net_en;
        pwc_word[wake_pkg::ENERGY_DETECT_ENABLE_BIT] = ctrl_q.energy_detect_enable;
        pwc_word[wake_pkg::TYPE_BIT] = ctrl_q.drive_pp;
        pwc_word[wake_pkg::CAUSE_HI:wake_pkg::CAUSE_LO] = cause_q;
        pwc_word[wake_pkg::PULSE_BIT] = ctrl_q.pulse;
        pwc_word[wake_pkg::POL_BIT] = ctrl_q.pol;
        pwc_word[wake_pkg::PIN_EN_BIT] = ctrl_q.pin_en;
        pwc_word[wake_pkg::READY_BIT] = ready;
    end

    always_comb
    begin
        read_mux = '0;
        if (hit_pwc)
            read_mux = pwc_word;
        else if (hit_hwcfg)
            read_mux = hwcfg_q;
        else if (hit_test && ready)
            read_mux = wake_pkg::BYTE_TEST_VALUE;
    end

    // read data and error captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= '0;
        else if (setup)
            rdata_q <= (!pwrite && rd_ok) ? read_mux : '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            err_q <= 1'b0;
        else if (setup)
            err_q <= pwrite ? !wr_ok : !rd_ok;
    end

    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = psel && penable && err_q;

    // device power state sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_STABILIZE;
        else
        begin
            case (state_q)
                ST_STABILIZE:
                    if (stable_done)
                        state_q <= ST_READY;
                ST_READY:
                    if (wr_pwc && new_pstate != wake_pkg::PS_NORMAL
                        && new_pstate != wake_pkg::PS_RESERVED)
                        state_q <= ST_REDUCED;
                ST_REDUCED:
                    if (wr_test)
                        state_q <= ST_STABILIZE;
                default:
                    state_q <= ST_STABILIZE;
            endcase
        end
    end

    // restart the stabilize timer after reset and after each wake
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_q <= 1'b1;
        else
            start_q <= (state_q == ST_REDUCED) && wr_test;
    end

    cycle_timer
    #(
        .WIDTH(TIMER_W),
        .LOAD(STABLE_CYCLES)
    )
    u_stable
    (
        .clk(pclk),
        .rst_n(presetn),
        .start(start_q),
        .busy(),
        .done(stable_done)
    );

    // control fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= wake_pkg::CTRL_RESET;
        else if (wr_pwc)
        begin
            if (new_pstate != wake_pkg::PS_RESERVED)
                ctrl_q.pstate <= new_pstate;
            ctrl_q.net_en <= pwdata[wake_pkg::NET_EN_BIT];
            ctrl_q.energy_detect_enable <= pwdata[wake_pkg::ENERGY_DETECT_ENABLE_BIT];
            ctrl_q.drive_pp <= pwdata[wake_pkg::TYPE_BIT];
            ctrl_q.pulse <= pwdata[wake_pkg::PULSE_BIT];
            ctrl_q.pol <= pwdata[wake_pkg::POL_BIT];
            ctrl_q.pin_en <= pwdata[wake_pkg::PIN_EN_BIT];
        end
        else if (state_q == ST_REDUCED && wr_test)
            ctrl_q.pstate <= wake_pkg::PS_NORMAL;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hwcfg_q <= wake_pkg::HWCFG_RESET;
        else if (wr_hwcfg)
            hwcfg_q <= pwdata;
    end

    // wake cause latching
    assign source_live[wake_pkg::CAUSE_ED_IDX] = energy_detect;
    assign source_live[wake_pkg::CAUSE_NET_IDX] = network_wake;

    assign cause_set[wake_pkg::CAUSE_ED_IDX] =
        ctrl_q.energy_detect_enable && energy_detect;
    assign cause_set[wake_pkg::CAUSE_NET_IDX] =
        ctrl_q.net_en && network_wake;

    // clear needs ready and a quiet source behind the bit
    assign cause_clr = (wr_pwc ? pwdata[wake_pkg::CAUSE_HI:wake_pkg::CAUSE_LO]
                               : 2'h0) & ~source_live;

    // a set in the same cycle as its clear wins
    assign cause_d = cause_set | (cause_q & ~cause_clr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cause_q <= wake_pkg::CAUSE_NONE;
        else
            cause_q <= cause_d;
    end

    // an event stays active while its cause and enable both hold
    assign wake_active =
        (cause_q[wake_pkg::CAUSE_ED_IDX] && ctrl_q.energy_detect_enable) ||
        (cause_q[wake_pkg::CAUSE_NET_IDX] && ctrl_q.net_en);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            active_q <= 1'b0;
        else
            active_q <= wake_active;
    end

    // a new pulse only on the rise of the combined event
    assign pulse_start = wake_active && !active_q;

    cycle_timer
    #(
        .WIDTH(TIMER_W),
        .LOAD(PULSE_CYCLES)
    )
    u_pulse
    (
        .clk(pclk),
        .rst_n(presetn),
        .start(pulse_start),
        .busy(pulse_busy),
        .done()
    );

    // pulse mode ends with the timer, static mode follows the event
    assign pin_assert = ctrl_q.pin_en && wake_active &&
        (ctrl_q.pulse ? pulse_busy : 1'b1);

    // pin drive: open drain pulls low only, push-pull follows polarity
    always_comb
    begin
        oe_d = pin_assert;
        pin_d = 1'b0;
        if (ctrl_q.drive_pp)
        begin
            oe_d = 1'b1;
            pin_d = ctrl_q.pol ? pin_assert : !pin_assert;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    // interrupt ignores the pin enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= wake_active;
    end

    assign wake_event_pin_o = pin_q;
    assign wake_event_pin_oe = oe_q;
    assign wake_interrupt = irq_q;
    assign power_state_select = ctrl_q.pstate;

endmodule : wake_event_indication

// ===== verification/wake_sva.sv
// Purpose: port checker of the wake block
// Assumes: zero-wait apb, registered outputs
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module wake_sva
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic network_wake, // net source
    input wire logic energy_detect, // energy source
    input wire logic wake_event_pin_o, // pin value
    input wire logic wake_event_pin_oe, // pin enable
    input wire logic wake_interrupt, // interrupt
    input wire logic [1:0] power_state_select // state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    wire logic src = network_wake || energy_detect;
    wire logic rd_ok = psel && penable && !pwrite &&
        (paddr == wake_pkg::PWC_OFF || paddr == wake_pkg::HWCFG_OFF);

    property p_rd_ok;
        rd_ok |-> !pslverr;
    endproperty
    a_rd_ok: assert property (p_rd_ok)
        else $error("control read refused");

    property p_err_zero;
        psel && penable && pslverr |-> prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused access returned data");

    property p_od_low;
        !wake_event_pin_oe |-> !wake_event_pin_o;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("released pin value not low");

    property p_int_rise;
        $rose(wake_interrupt) |-> $past(src, 2) || $past(wr, 2);
    endproperty
    a_int_rise: assert property (p_int_rise)
        else $error("interrupt rose without cause");

    property p_int_fall;
        $fell(wake_interrupt) |-> $past(wr, 2);
    endproperty
    a_int_fall: assert property (p_int_fall)
        else $error("interrupt fell without clear");

    property p_oe_rise;
        $rose(wake_event_pin_oe) |-> $past(src, 2) || $past(wr, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("pin drive rose without cause");

    property p_ps_change;
        $changed(power_state_select) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_ps_change: assert property (p_ps_change)
        else $error("power state moved without write");

    property p_ps_code;
        power_state_select != wake_pkg::PS_RESERVED;
    endproperty
    a_ps_code: assert property (p_ps_code)
        else $error("reserved power state entered");
endmodule : wake_sva

bind wake_event_indication wake_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .network_wake(network_wake), .energy_detect(energy_detect),
    .wake_event_pin_o(wake_event_pin_o),
    .wake_event_pin_oe(wake_event_pin_oe),
    .wake_interrupt(wake_interrupt),
    .power_state_select(power_state_select));

// ===== verification/wake_pin_host.sv
// Purpose: host side of the wake pin wire
// Assumes: board pull-up on the pin
// Notes: resolves the wire level the host sees
`timescale 1ns/10ps
module wake_pin_host
(
    input wire logic pin_o, // design pin value
    input wire logic pin_oe, // design pin enable
    output logic level // resolved wire level
);
    // released line floats up to the pull-up, never to x
    assign level = pin_oe ? pin_o : 1'b1;
endmodule : wake_pin_host

// ===== verification/wake_event_indication_test.sv
// Purpose: self-checking bench of the wake block
// Assumes: zero-wait apb, short pulse and settle counts
// Notes: random data from a fixed seed
`timescale 1ns/10ps
module wake_event_indication_test;
    localparam int PC = 20;
    localparam logic [11:0] PWC = wake_pkg::PWC_OFF;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic network_wake, energy_detect, pin_o, pin_oe, wake_interrupt, lvl;
    logic [1:0] power_state_select;
    int bad_count, cmp_count, seed, n;

    wake_event_indication #(.PULSE_CYCLES(PC), .STABLE_CYCLES(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .network_wake(network_wake),
        .energy_detect(energy_detect), .wake_event_pin_o(pin_o),
        .wake_event_pin_oe(pin_oe), .wake_interrupt(wake_interrupt),
        .power_state_select(power_state_select));
    wake_pin_host host (.pin_o(pin_o), .pin_oe(pin_oe), .level(lvl));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task final_report;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        cmp_count++;
        if (got !== ex)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // push-pull active high follows act, every other mode is active low
    function automatic logic lvl_exp(input logic pp, input logic pol,
        input logic act);
        return (pp && pol) ? act : !act;
    endfunction : lvl_exp

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            bad_count++;
            final_report;
        end
    endtask : apb

    task wait_ready;
        int k;
        k = 0;
        do
        begin
            apb(1'b0, PWC, 32'h0);
            k++;
        end
        while (rd[0] !== 1'b1 && k < 40);
        if (rd[0] !== 1'b1)
        begin
            bad_count++;
            final_report;
        end
    endtask : wait_ready

    initial
    begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        final_report;
    end

    initial
    begin
        seed = 32'h201fe7d8;
        bad_count = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        network_wake = 1'b0;
        energy_detect = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PWC, 32'h0);
        chk("ctrl at reset", rd, 32'h0);
        chk("ctrl read err", er, 1'b0);
        apb(1'b0, wake_pkg::BYTE_TEST_OFF, 32'h0);
        chk("early read err", er, 1'b1);
        apb(1'b0, wake_pkg::HWCFG_OFF, 32'h0);
        chk("config read err", er, 1'b0);
        wait_ready;
        chk("idle pin", lvl, 1'b1);
        repeat (4)
        begin
            v = $random(seed);
            apb(1'b1, wake_pkg::HWCFG_OFF, v);
            apb(1'b0, wake_pkg::HWCFG_OFF, 32'h0);
            chk("config data", rd, v);
        end
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped err", er, 1'b1);
        apb(1'b0, wake_pkg::BYTE_TEST_OFF, 32'h0);
        chk("byte test", rd, wake_pkg::BYTE_TEST_VALUE);
        // open drain with polarity set, which must be ignored
        apb(1'b1, PWC, 32'h206);
        network_wake <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("interrupt", wake_interrupt, 1'b1);
        chk("od pin", lvl, lvl_exp(1'b0, 1'b1, 1'b1));
        apb(1'b1, PWC, 32'h236);
        apb(1'b0, PWC, 32'h0);
        chk("cause held", rd[5:4], wake_pkg::CAUSE_NET);
        chk("static pin", lvl, 1'b0);
        network_wake <= 1'b0;
        apb(1'b1, PWC, 32'h236);
        repeat (2) @(posedge pclk);
        chk("pin released", lvl, 1'b1);
        chk("int released", wake_interrupt, 1'b0);
        apb(1'b1, PWC, 32'h144);
        energy_detect <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("interrupt", wake_interrupt, 1'b1);
        chk("gated pin", lvl, lvl_exp(1'b1, 1'b1, 1'b0));
        apb(1'b1, PWC, 32'h146);
        repeat (2) @(posedge pclk);
        chk("pp pin", lvl, lvl_exp(1'b1, 1'b1, 1'b1));
        apb(1'b1, PWC, 32'h346);
        network_wake <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, PWC, 32'h0);
        chk("cause multi", rd[5:4], wake_pkg::CAUSE_MULTI);
        apb(1'b1, PWC, 32'h046);
        repeat (2) @(posedge pclk);
        chk("enable off pin", lvl, lvl_exp(1'b1, 1'b1, 1'b0));
        network_wake <= 1'b0;
        energy_detect <= 1'b0;
        apb(1'b1, PWC, 32'h030);
        apb(1'b1, PWC, 32'h14A);
        energy_detect <= 1'b1;
        n = 0;
        repeat (40)
        begin
            @(negedge pclk);
            if (lvl === 1'b0)
                n++;
        end
        chk("pulse cycles", 32'(n), 32'(PC));
        apb(1'b0, PWC, 32'h0);
        chk("cause latched", rd[5:4], wake_pkg::CAUSE_ENERGY);
        energy_detect <= 1'b0;
        apb(1'b1, PWC, 32'h010);
        apb(1'b1, PWC, 32'h3000);
        @(posedge pclk);
        chk("reserved state", power_state_select, 2'h0);
        for (n = 1; n < 3; n++)
        begin
            apb(1'b1, PWC, 32'(n) << 12);
            @(posedge pclk);
            chk("reduced state", power_state_select, 32'(n));
            apb(1'b0, PWC, 32'h0);
            chk("not ready", rd[0], 1'b0);
            v = $random(seed);
            apb(1'b1, wake_pkg::BYTE_TEST_OFF, v);
            wait_ready;
            chk("woken state", power_state_select, 2'h0);
        end
        final_report;
    end
endmodule : wake_event_indication_test
